// [design/psdl_pkg.sv]
// Constants, types and register map of the port strap default loader
package psdl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTL_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h4;
    localparam logic [3:0] DFLT_OFFSET = 4'h8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_OVERRIDE_BIT = 0;
    localparam int CTL_SW_AUTO_BIT = 1;
    localparam int CTL_SW_MDIX_BIT = 2;
    localparam int CTL_TX_PAUSE_BIT = 3;
    localparam int CTL_RX_PAUSE_BIT = 4;
    localparam int CTL_RELOAD_BIT = 8;
    localparam logic CTL_OVERRIDE_RST = 1'b0;
    localparam logic CTL_SW_AUTO_RST = 1'b1;
    localparam logic CTL_SW_MDIX_RST = 1'b0;
    localparam logic CTL_TX_PAUSE_RST = 1'b1;
    localparam logic CTL_RX_PAUSE_RST = 1'b1;

    // ------------------------------------------------------------
    // Status and defaults register fields
    // ------------------------------------------------------------
    localparam int STAT_STRAP_LSB = 0;
    localparam int STAT_LOADED_BIT = 8;
    localparam int DFLT_ADV_LSB = 0;
    localparam int DFLT_MODE_LSB = 16;
    localparam int DFLT_SPEED_BIT = 19;
    localparam int DFLT_DUPLEX_BIT = 20;
    localparam int DFLT_NEG_BIT = 21;
    localparam int DFLT_XAUTO_BIT = 22;
    localparam int DFLT_MDIX_BIT = 23;
    localparam int DFLT_P1ADV_BIT = 24;
    localparam int DFLT_P1MAN_BIT = 25;

    // ------------------------------------------------------------
    // Advertisement word layout and PHY mode codes
    // ------------------------------------------------------------
    localparam int ADV_PAUSE_BIT = 10;
    localparam int ADV_100FD_BIT = 8;
    localparam int ADV_100HD_BIT = 7;
    localparam int ADV_10FD_BIT = 6;
    localparam int ADV_10HD_BIT = 5;
    localparam logic [4:0] ADV_SELECTOR = 5'h01;
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7;

    // ------------------------------------------------------------
    // Strap reset values and settle timing
    // ------------------------------------------------------------
    localparam logic STRAP_MANUAL_FC_DFLT = 1'b0;
    localparam logic STRAP_MANUAL_MDIX_DFLT = 1'b0;
    localparam logic STRAP_AUTONEG_DFLT = 1'b1;
    localparam logic STRAP_SPEED_DFLT = 1'b1;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STRAP_SETTLE_NS = 150;
    localparam int SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic duplex;
        logic speed;
        logic autoneg;
        logic manual_mdix;
        logic auto_mdix;
        logic manual_fc;
    } psdl_strap_s;

    typedef struct packed {
        logic rx_pause;
        logic tx_pause;
        logic sw_mdix;
        logic sw_auto;
        logic override;
    } psdl_ctl_s;

    typedef enum logic [1:0] {
        PS_SETTLE,
        PS_CAPTURE,
        PS_READY
    } psdl_state_e;

endpackage

// [design/psdl_sync.sv]
// Two flip-flop synchroniser for the strap pins
`timescale 1ns/1ps
`default_nettype none

module psdl_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

`default_nettype wire

// [design/psdl_loader.sv]
// Strap capture and reset default loader for port 1 pause and port 2 PHY bits
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Manual pause strap low: advertise symmetric pause
// - Strap high: use tx/rx bits, clear advert
// - Override clear: crossover strap sets auto enable
// - Override set: crossover strap ignored
// - Override clear, no auto crossover: manual strap picks MDI/MDIX
// - Negotiation strap sets negotiation enable default
// - Negotiation strap shapes duplex, advert, mode
// - Speed strap sets speed-select low bit
// - Speed strap shapes 10BASE-T advert bits
module psdl_loader (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Strap pins
    input wire logic port1_manual_pause_select_strap_i,
    input wire logic port2_auto_mdix_strap_i,
    input wire logic port2_manual_mdix_strap_i,
    input wire logic port2_negotiation_strap_i,
    input wire logic port2_speed_strap_i,
    input wire logic port2_duplex_strap_i,
    // Negotiated pause result for port 1
    input wire logic port1_an_tx_pause_i,
    input wire logic port1_an_rx_pause_i,
    // Avalon-MM slave
    input wire logic [psdl_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Port 1 pause control
    output logic port1_manual_pause_select_o,
    output logic port1_advert_pause_o,
    output logic port1_tx_pause_enable_o,
    output logic port1_rx_pause_enable_o,
    // Port 2 PHY defaults
    output logic [15:0] port2_advert_o,
    output logic port2_crossover_auto_o,
    output logic port2_mdix_select_o,
    output logic port2_negotiation_enable_o,
    output logic port2_speed_select_low_o,
    output logic port2_duplex_select_o,
    output logic [2:0] port2_phy_mode_o,
    output logic defaults_valid_o
);

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------
    psdl_pkg::psdl_strap_s strap_pins;
    psdl_pkg::psdl_strap_s strap_sync;
    psdl_pkg::psdl_strap_s cap_r;
    psdl_pkg::psdl_ctl_s ctl_r;
    psdl_pkg::psdl_state_e state_r;
    logic [1:0] settle_cnt_r;
    logic loaded_r;
    logic reload_req;
    logic bus_req;
    logic bus_hit;
    logic [1:0] word_sel;
    logic [31:0] rd_mux;
    logic adv10;
    logic [15:0] adv_nxt;

    assign strap_pins = '{
        duplex: port2_duplex_strap_i,
        speed: port2_speed_strap_i,
        autoneg: port2_negotiation_strap_i,
        manual_mdix: port2_manual_mdix_strap_i,
        auto_mdix: port2_auto_mdix_strap_i,
        manual_fc: port1_manual_pause_select_strap_i
    };

    psdl_sync #(
        .WIDTH($bits(psdl_pkg::psdl_strap_s))
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(strap_pins),
        .sync_o(strap_sync)
    );

    // ------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= psdl_pkg::PS_SETTLE;
            settle_cnt_r <= '0;
        end else if (reload_req) begin
            state_r <= psdl_pkg::PS_SETTLE;
            settle_cnt_r <= '0;
        end else begin
            unique case (state_r)
                psdl_pkg::PS_SETTLE: begin
                    settle_cnt_r <= settle_cnt_r + 2'd1;
                    if (settle_cnt_r == 2'(psdl_pkg::SETTLE_CYC - 1)) begin
                        state_r <= psdl_pkg::PS_CAPTURE;
                    end
                end
                psdl_pkg::PS_CAPTURE: begin
                    state_r <= psdl_pkg::PS_READY;
                end
                psdl_pkg::PS_READY: begin
                    state_r <= psdl_pkg::PS_READY;
                end
            endcase
        end
    end

    // Capture and loaded flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_r <= '{
                duplex: 1'b1,
                speed: psdl_pkg::STRAP_SPEED_DFLT,
                autoneg: psdl_pkg::STRAP_AUTONEG_DFLT,
                manual_mdix: psdl_pkg::STRAP_MANUAL_MDIX_DFLT,
                auto_mdix: 1'b0,
                manual_fc: psdl_pkg::STRAP_MANUAL_FC_DFLT
            };
            loaded_r <= 1'b0;
        end else if (reload_req) begin
            loaded_r <= 1'b0;
        end else if (state_r == psdl_pkg::PS_CAPTURE) begin
            cap_r <= strap_sync;
        end else if (state_r == psdl_pkg::PS_READY) begin
            // One cycle late so crossover and pause outputs have settled
            loaded_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Derived defaults
    // ------------------------------------------------------------
    assign adv10 = !strap_sync.autoneg || !strap_sync.speed;

    always_comb begin
        adv_nxt = '0;
        adv_nxt[4:0] = psdl_pkg::ADV_SELECTOR;
        adv_nxt[psdl_pkg::ADV_10HD_BIT] = adv10;
        adv_nxt[psdl_pkg::ADV_10FD_BIT] = adv10 && strap_sync.duplex;
        adv_nxt[psdl_pkg::ADV_100HD_BIT] = strap_sync.speed;
        adv_nxt[psdl_pkg::ADV_100FD_BIT] = strap_sync.speed && strap_sync.duplex;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port2_advert_o <= '0;
            port2_negotiation_enable_o <= psdl_pkg::STRAP_AUTONEG_DFLT;
            port2_speed_select_low_o <= psdl_pkg::STRAP_SPEED_DFLT;
            port2_duplex_select_o <= 1'b1;
            port2_phy_mode_o <= psdl_pkg::MODE_ALL_CAPABLE;
            port1_manual_pause_select_o <= psdl_pkg::STRAP_MANUAL_FC_DFLT;
            port1_advert_pause_o <= 1'b0;
        end else if (state_r == psdl_pkg::PS_CAPTURE) begin
            port2_advert_o <= adv_nxt;
            port2_negotiation_enable_o <= strap_sync.autoneg;
            port2_speed_select_low_o <= strap_sync.speed;
            port2_duplex_select_o <= strap_sync.duplex || strap_sync.autoneg;
            if (strap_sync.autoneg) begin
                port2_phy_mode_o <= psdl_pkg::MODE_ALL_CAPABLE;
            end else begin
                port2_phy_mode_o <= {1'b0, strap_sync.speed, strap_sync.duplex};
            end
            port1_manual_pause_select_o <= strap_sync.manual_fc;
            port1_advert_pause_o <= !strap_sync.manual_fc;
        end
    end

    assign defaults_valid_o = loaded_r;

    // ------------------------------------------------------------
    // Live crossover and pause selection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port2_crossover_auto_o <= 1'b0;
            port2_mdix_select_o <= 1'b0;
        end else if (ctl_r.override) begin
            port2_crossover_auto_o <= ctl_r.sw_auto;
            port2_mdix_select_o <= ctl_r.sw_mdix;
        end else begin
            port2_crossover_auto_o <= cap_r.auto_mdix;
            port2_mdix_select_o <= cap_r.auto_mdix ? 1'b0 : cap_r.manual_mdix;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port1_tx_pause_enable_o <= 1'b0;
            port1_rx_pause_enable_o <= 1'b0;
        end else if (port1_manual_pause_select_o) begin
            port1_tx_pause_enable_o <= ctl_r.tx_pause;
            port1_rx_pause_enable_o <= ctl_r.rx_pause;
        end else begin
            port1_tx_pause_enable_o <= port1_an_tx_pause_i;
            port1_rx_pause_enable_o <= port1_an_rx_pause_i;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    assign bus_req = avs_read_i || avs_write_i;
    assign word_sel = avs_address_i[3:2];
    assign bus_hit = avs_address_i[1:0] == 2'b00 && word_sel != 2'b11;
    assign reload_req = avs_write_i && !avs_waitrequest_o && bus_hit
        && avs_address_i == psdl_pkg::CTL_OFFSET && avs_byteenable_i[1]
        && avs_writedata_i[psdl_pkg::CTL_RELOAD_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (!avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_req && loaded_r) begin
            avs_waitrequest_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= '{
                rx_pause: psdl_pkg::CTL_RX_PAUSE_RST,
                tx_pause: psdl_pkg::CTL_TX_PAUSE_RST,
                sw_mdix: psdl_pkg::CTL_SW_MDIX_RST,
                sw_auto: psdl_pkg::CTL_SW_AUTO_RST,
                override: psdl_pkg::CTL_OVERRIDE_RST
            };
        end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                     && avs_address_i == psdl_pkg::CTL_OFFSET) begin
            ctl_r.override <= avs_writedata_i[psdl_pkg::CTL_OVERRIDE_BIT];
            ctl_r.sw_auto <= avs_writedata_i[psdl_pkg::CTL_SW_AUTO_BIT];
            ctl_r.sw_mdix <= avs_writedata_i[psdl_pkg::CTL_SW_MDIX_BIT];
            ctl_r.tx_pause <= avs_writedata_i[psdl_pkg::CTL_TX_PAUSE_BIT];
            ctl_r.rx_pause <= avs_writedata_i[psdl_pkg::CTL_RX_PAUSE_BIT];
        end
    end

    always_comb begin
        rd_mux = '0;
        if (bus_hit) begin
            unique case (word_sel)
                2'd0: begin
                    rd_mux[psdl_pkg::CTL_OVERRIDE_BIT] = ctl_r.override;
                    rd_mux[psdl_pkg::CTL_SW_AUTO_BIT] = ctl_r.sw_auto;
                    rd_mux[psdl_pkg::CTL_SW_MDIX_BIT] = ctl_r.sw_mdix;
                    rd_mux[psdl_pkg::CTL_TX_PAUSE_BIT] = ctl_r.tx_pause;
                    rd_mux[psdl_pkg::CTL_RX_PAUSE_BIT] = ctl_r.rx_pause;
                end
                2'd1: begin
                    rd_mux[psdl_pkg::STAT_STRAP_LSB +: 6] = cap_r;
                    rd_mux[psdl_pkg::STAT_LOADED_BIT] = loaded_r;
                end
                2'd2: begin
                    rd_mux[psdl_pkg::DFLT_ADV_LSB +: 16] = port2_advert_o;
                    rd_mux[psdl_pkg::DFLT_MODE_LSB +: 3] = port2_phy_mode_o;
                    rd_mux[psdl_pkg::DFLT_SPEED_BIT] = port2_speed_select_low_o;
                    rd_mux[psdl_pkg::DFLT_DUPLEX_BIT] = port2_duplex_select_o;
                    rd_mux[psdl_pkg::DFLT_NEG_BIT] = port2_negotiation_enable_o;
                    rd_mux[psdl_pkg::DFLT_XAUTO_BIT] = port2_crossover_auto_o;
                    rd_mux[psdl_pkg::DFLT_MDIX_BIT] = port2_mdix_select_o;
                    rd_mux[psdl_pkg::DFLT_P1ADV_BIT] = port1_advert_pause_o;
                    rd_mux[psdl_pkg::DFLT_P1MAN_BIT] = port1_manual_pause_select_o;
                end
                default: begin
                    rd_mux = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o && loaded_r) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_pause_advert;
        loaded_r && !cap_r.manual_fc |-> port1_advert_pause_o;
    endproperty
    a_pause_advert: assert property (p_pause_advert) else $error("Pause not advertised");

    property p_manual_pause;
        loaded_r && port1_manual_pause_select_o
            |=> !port1_advert_pause_o && port1_tx_pause_enable_o == $past(ctl_r.tx_pause)
                && port1_rx_pause_enable_o == $past(ctl_r.rx_pause);
    endproperty
    a_manual_pause: assert property (p_manual_pause) else $error("Manual pause wrong");

    property p_xover_strap;
        !ctl_r.override |=> port2_crossover_auto_o == $past(cap_r.auto_mdix);
    endproperty
    a_xover_strap: assert property (p_xover_strap) else $error("Crossover strap ignored");

    property p_xover_override;
        ctl_r.override |=> port2_crossover_auto_o == $past(ctl_r.sw_auto)
            && port2_mdix_select_o == $past(ctl_r.sw_mdix);
    endproperty
    a_xover_override: assert property (p_xover_override) else $error("Override not obeyed");

    property p_manual_mdix;
        !ctl_r.override && !cap_r.auto_mdix |=> port2_mdix_select_o == $past(cap_r.manual_mdix);
    endproperty
    a_manual_mdix: assert property (p_manual_mdix) else $error("MDI/MDIX select wrong");

    property p_neg_load;
        state_r == psdl_pkg::PS_CAPTURE && !reload_req
            |=> port2_negotiation_enable_o == $past(strap_sync.autoneg)
                && port2_speed_select_low_o == $past(strap_sync.speed);
    endproperty
    a_neg_load: assert property (p_neg_load) else $error("Negotiation or speed load wrong");

    property p_neg_mode;
        loaded_r && port2_negotiation_enable_o
            |-> port2_phy_mode_o == psdl_pkg::MODE_ALL_CAPABLE && port2_duplex_select_o;
    endproperty
    a_neg_mode: assert property (p_neg_mode) else $error("Mode not all capable");

    property p_speed_load;
        loaded_r |-> port2_speed_select_low_o == cap_r.speed;
    endproperty
    a_speed_load: assert property (p_speed_load) else $error("Speed bit differs");

    property p_speed_advert;
        loaded_r
            |-> port2_advert_o[psdl_pkg::ADV_10HD_BIT]
                    == (!port2_negotiation_enable_o || !port2_speed_select_low_o)
                && port2_advert_o[psdl_pkg::ADV_10FD_BIT]
                    == (port2_advert_o[psdl_pkg::ADV_10HD_BIT] && cap_r.duplex);
    endproperty
    a_speed_advert: assert property (p_speed_advert) else $error("10BASE-T advert wrong");

    property p_load_time;
        state_r == psdl_pkg::PS_SETTLE && settle_cnt_r == 2'd0 && !reload_req
            |-> !loaded_r ##[1:6] loaded_r;
    endproperty
    a_load_time: assert property (p_load_time) else $error("Defaults not loaded in time");

    property p_wait_until_loaded;
        !loaded_r |=> avs_waitrequest_o;
    endproperty
    a_wait_until_loaded: assert property (p_wait_until_loaded) else $error("Bus answered early");

    c_reload: cover property (reload_req ##[1:8] loaded_r);
    c_override: cover property (ctl_r.override && port2_mdix_select_o);
    c_manual_fc: cover property (loaded_r && port1_manual_pause_select_o);
    c_forced_10: cover property (loaded_r && !port2_negotiation_enable_o && !port2_speed_select_low_o);

endmodule

`default_nettype wire

// [sim/psdl_loader_bench.sv]
// Self-checking bench for the port strap default loader
`timescale 1ns/1ps
`default_nettype none

module psdl_loader_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    typedef struct packed {logic [5:0] s; logic [31:0] d;} psdl_row_s;
    psdl_row_s rows [4];
    logic clk_i, rst_i, an_tx, an_rx, rd, wr, waitreq, p1man, p1adv, tx_en, rx_en;
    logic xauto, mdix, neg, spd, dup, valid;
    logic [5:0] straps;
    logic [3:0] addr, be;
    logic [31:0] wdata, rdata, rd_v;
    logic [15:0] adv;
    logic [2:0] mode;
    int miscompares = 0;
    int n_compared = 0;

    psdl_loader DUT (
        .clk_i(clk_i), .rst_i(rst_i),
        .port1_manual_pause_select_strap_i(straps[0]), .port2_auto_mdix_strap_i(straps[1]),
        .port2_manual_mdix_strap_i(straps[2]), .port2_negotiation_strap_i(straps[3]),
        .port2_speed_strap_i(straps[4]), .port2_duplex_strap_i(straps[5]),
        .port1_an_tx_pause_i(an_tx), .port1_an_rx_pause_i(an_rx),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .port1_manual_pause_select_o(p1man), .port1_advert_pause_o(p1adv),
        .port1_tx_pause_enable_o(tx_en), .port1_rx_pause_enable_o(rx_en),
        .port2_advert_o(adv), .port2_crossover_auto_o(xauto), .port2_mdix_select_o(mdix),
        .port2_negotiation_enable_o(neg), .port2_speed_select_low_o(spd),
        .port2_duplex_select_o(dup), .port2_phy_mode_o(mode), .defaults_valid_o(valid)
    );

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        #(50 * 5000);
        miscompares++;
        wrap_up();
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitreq !== 1'b0);
        chk(n, 32'd2);
        rd_v = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (valid !== 1'b1 && n < 20);
        chk(n >= 4, 1'b1);
        chk(valid, 1'b1);
    endtask

    task automatic load(input logic [5:0] s);
        @(posedge clk_i);
        straps <= s;
        bus(1'b1, psdl_pkg::CTL_OFFSET, 32'h0000_011A);
        wait_valid();
    endtask

    function automatic logic [31:0] outs();
        return {6'h00, p1man, p1adv, mdix, xauto, neg, dup, spd, mode, adv};
    endfunction

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{6'b111010, 32'h017F_0181}, '{6'b001101, 32'h02B7_0021},
                 '{6'b010000, 32'h010A_00A1}, '{6'b100111, 32'h0251_0061}};
        rst_i = 1'b1;
        straps = 6'b111010;
        {an_tx, an_rx, rd, wr} = 4'h0;
        addr = 4'h0;
        be = 4'hF;
        wdata = 32'h0000_0000;
        repeat (2) @(negedge clk_i);
        chk({valid, waitreq}, 2'b01);
        chk(outs(), 32'h003F_0000);
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk(valid, 1'b0);
        wait_valid();
        chk(outs(), rows[0].d);
        for (int i = 0; i < 4; i++) begin
            load(rows[i].s);
            chk(outs(), rows[i].d);
            bus(1'b0, psdl_pkg::DFLT_OFFSET, 32'h0);
            chk(rd_v, rows[i].d);
            bus(1'b0, psdl_pkg::STAT_OFFSET, 32'h0);
            chk(rd_v, {24'h0000_01, 2'b00, rows[i].s});
        end
        // Manual pause uses software bits, then override takes crossover from sw_auto/sw_mdix
        bus(1'b1, psdl_pkg::CTL_OFFSET, 32'h0000_0012);
        repeat (2) @(negedge clk_i);
        chk({tx_en, rx_en}, 2'b01);
        bus(1'b1, psdl_pkg::CTL_OFFSET, 32'h0000_001D);
        repeat (2) @(negedge clk_i);
        chk({xauto, mdix}, 2'b01);
        bus(1'b1, psdl_pkg::CTL_OFFSET, 32'h0000_001B);
        repeat (2) @(negedge clk_i);
        chk({xauto, mdix}, 2'b10);
        // Negotiated pause once the manual strap is low
        @(posedge clk_i);
        {an_tx, an_rx} <= 2'b10;
        load(rows[2].s);
        chk(outs(), rows[2].d);
        chk({tx_en, rx_en}, 2'b10);
        @(posedge clk_i);
        {an_tx, an_rx} <= 2'b01;
        straps <= 6'b101111;
        repeat (8) @(negedge clk_i);
        chk({tx_en, rx_en}, 2'b01);
        chk(outs(), rows[2].d);
        bus(1'b0, 4'hC, 32'h0);
        chk(rd_v, 32'h0000_0000);
        // Write with no byte lanes: no reload, control bits kept
        be <= 4'h0;
        bus(1'b1, psdl_pkg::CTL_OFFSET, 32'h0000_0100);
        be <= 4'hF;
        bus(1'b0, psdl_pkg::STAT_OFFSET, 32'h0);
        chk(rd_v, {24'h0000_01, 2'b00, rows[2].s});
        bus(1'b0, psdl_pkg::CTL_OFFSET, 32'h0);
        chk(rd_v, 32'h0000_001A);
        // Mid-run reset reloads the straps
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk({valid, waitreq}, 2'b01);
        @(posedge clk_i);
        rst_i <= 1'b0;
        wait_valid();
        chk(outs(), 32'h0277_0061);
        wrap_up();
    end
endmodule

`default_nettype wire
